// ---- hw/aam_device.sv ----
// Our own choices: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
`include "aam_consts.svh"

// Behaviour
// (RULE1) Eleven-bit successive approximation, sixteen-bit result fields
// (RULE2) Host sends opcode, enable byte, config byte
// (RULE3) Enable byte: temp, supply, pin, pin select
// (RULE4) Reply: ready byte, pin, supply, temp, two reserved
// (RULE5) Disabled channel skipped, its field zero
// (RULE6) Host: temperature equals raw times 568/2560 minus 297
// (RULE7) Host: supply volts equals three times raw over 1280
// (RULE8) Host: pin volts equals raw over attenuation divisor
// (RULE9) Pin select picks pin 0 to 3
// (RULE10) Conversion time from clock, divider, upper nibble
// (RULE11) Zero config byte means 0xC for both
// (RULE12) Attenuation codes select pin input range
// (RULE13) Shorter conversion setting gives fewer result bits
// (RULE14) Ready byte held back until results valid
module aam_device import aam_pkg::*; #(
    parameter int unsigned CONV_DIVIDER = `AAM_CONV_DIVIDER
) (
    // Clock and reset
    input wire logic I_CLOCK,
    input wire logic I_NRST,
    // Link to host
    aam_link.device LINK,
    // Analog front end
    input wire logic I_COMPARE,
    output logic [10:0] O_DAC_CODE,
    output logic [2:0] O_MUX_SEL,
    output logic [3:0] O_PIN_ATTENUATION,
    output logic O_CONVERTING
);

    aam_dev_state_t state;
    logic [7:0] en;
    logic [7:0] cfg;
    logic [1:0] ch;
    logic [3:0] slot;
    logic [23:0] timer;
    logic [10:0] code;
    logic [15:0] result [0:2];
    logic [3:0] reply_idx;
    logic [7:0] rsp_byte;
    logic cmp_meta;
    logic cmp_sync;
    logic cmd_fire;
    logic rsp_fire;
    logic ch_on;
    logic slot_end;
    logic bit_slot;
    logic conv_step_done;
    logic conv_all_done;
    logic [3:0] nbits;
    logic [23:0] slot_len;
    logic [31:0] conv_total;
    logic [10:0] bit_mask;
    logic [7:0] next_rsp_byte;

    // Comparator comes from the analog side
    always_ff @(posedge I_CLOCK) begin
        if (!I_NRST) begin
            cmp_meta <= 1'b0;
            cmp_sync <= 1'b0;
        end else begin
            cmp_meta <= I_COMPARE;
            cmp_sync <= cmp_meta;
        end
    end

    assign cmd_fire = LINK.cmd_valid & LINK.cmd_ready;
    assign rsp_fire = LINK.rsp_valid & LINK.rsp_ready;
    assign LINK.cmd_ready = (state == AAM_DEV_IDLE) | (state == AAM_DEV_GET_EN) | (state == AAM_DEV_GET_CFG);
    assign LINK.rsp_valid = (state == AAM_DEV_REPLY); // [RULE14]
    assign LINK.rsp_data = rsp_byte;

    always_comb begin
        case (ch)
            `AAM_CH_PIN: ch_on = en[`AAM_EN_PIN_BIT];
            `AAM_CH_SUPPLY: ch_on = en[`AAM_EN_SUPPLY_BIT];
            default: ch_on = en[`AAM_EN_TEMP_BIT];
        endcase
    end

    // Whole conversion is 16 slots; a slot never drops below the sync latency
    assign conv_total = 32'(CONV_DIVIDER) << (cfg[7:4] + 5'd1); // [RULE10]
    assign slot_len = (conv_total[27:4] < `AAM_SLOT_MIN) ? `AAM_SLOT_MIN : conv_total[27:4]; // [RULE10]
    // Short settings resolve fewer bits, low bits stay zero
    assign nbits = (cfg[7:4] >= `AAM_FULL_RES_SETTING) ? 4'(`AAM_SAR_BITS) : cfg[7:4] + 4'd1; // [RULE13]
    assign slot_end = (timer == slot_len - 24'd1);
    assign bit_slot = (slot < nbits);
    assign bit_mask = `AAM_SAR_MSB_MASK >> slot;
    assign conv_step_done = !ch_on | (slot_end & (slot == `AAM_SLOT_LAST));
    assign conv_all_done = (state == AAM_DEV_CONVERT) & conv_step_done & (ch == `AAM_CH_TEMP);

    // Command and sequencing
    always_ff @(posedge I_CLOCK) begin
        if (!I_NRST) begin
            state <= AAM_DEV_IDLE;
            en <= 8'h00;
            cfg <= `AAM_CFG_DEFAULT;
        end else begin
            case (state)
                AAM_DEV_IDLE: begin
                    // Anything but the opcode is dropped
                    if (cmd_fire && LINK.cmd_data == `AAM_OPCODE) begin // [RULE2]
                        state <= AAM_DEV_GET_EN;
                    end
                end
                AAM_DEV_GET_EN: begin
                    if (cmd_fire) begin
                        en <= LINK.cmd_data & `AAM_EN_USED_MASK; // [RULE3]
                        state <= AAM_DEV_GET_CFG;
                    end
                end
                AAM_DEV_GET_CFG: begin
                    if (cmd_fire) begin
                        if (LINK.cmd_data == 8'h00) begin
                            cfg <= `AAM_CFG_DEFAULT; // [RULE11]
                        end else begin
                            cfg <= LINK.cmd_data;
                        end
                        state <= AAM_DEV_CONVERT;
                    end
                end
                AAM_DEV_CONVERT: begin
                    if (conv_all_done) begin
                        state <= AAM_DEV_REPLY; // [RULE14]
                    end
                end
                AAM_DEV_REPLY: begin
                    if (rsp_fire && reply_idx == `AAM_REPLY_LAST) begin
                        state <= AAM_DEV_IDLE;
                    end
                end
                default: state <= AAM_DEV_IDLE;
            endcase
        end
    end

    // Successive approximation datapath
    always_ff @(posedge I_CLOCK) begin
        if (!I_NRST) begin
            ch <= `AAM_CH_PIN;
            slot <= 4'h0;
            timer <= 24'h00_0000;
            code <= 11'h000;
            for (int i = 0; i < 3; i++) begin
                result[i] <= 16'h0000;
            end
        end else if (state == AAM_DEV_GET_CFG && cmd_fire) begin
            ch <= `AAM_CH_PIN;
            slot <= 4'h0;
            timer <= 24'h00_0000;
            code <= 11'h000;
            for (int i = 0; i < 3; i++) begin
                result[i] <= 16'h0000; // [RULE5]
            end
        end else if (state == AAM_DEV_CONVERT) begin
            if (!ch_on) begin
                ch <= ch + 2'd1; // [RULE5]
            end else begin
                timer <= slot_end ? 24'h00_0000 : timer + 24'd1;
                if (slot_end) begin
                    slot <= slot + 4'd1;
                    if (slot == `AAM_SLOT_LAST) begin
                        result[ch] <= {5'h00, code}; // [RULE1]
                        code <= 11'h000;
                        ch <= ch + 2'd1;
                    end else if (bit_slot && !cmp_sync) begin
                        code <= code & ~bit_mask; // [RULE1]
                    end
                end else if (timer == 24'h00_0000 && bit_slot) begin
                    code <= code | bit_mask; // [RULE1]
                end
            end
        end
    end

    always_comb begin
        case (reply_idx + 4'd1)
            4'h1: next_rsp_byte = result[`AAM_CH_PIN][15:8];
            4'h2: next_rsp_byte = result[`AAM_CH_PIN][7:0];
            4'h3: next_rsp_byte = result[`AAM_CH_SUPPLY][15:8];
            4'h4: next_rsp_byte = result[`AAM_CH_SUPPLY][7:0];
            4'h5: next_rsp_byte = result[`AAM_CH_TEMP][15:8];
            4'h6: next_rsp_byte = result[`AAM_CH_TEMP][7:0];
            default: next_rsp_byte = 8'h00;
        endcase
    end

    // Reply stream, high byte first
    always_ff @(posedge I_CLOCK) begin
        if (!I_NRST) begin
            reply_idx <= 4'h0;
            rsp_byte <= 8'h00;
        end else if (conv_all_done) begin
            reply_idx <= 4'h0;
            rsp_byte <= `AAM_CTS_BYTE; // [RULE4]
        end else if (rsp_fire) begin
            reply_idx <= reply_idx + 4'd1;
            rsp_byte <= next_rsp_byte; // [RULE4]
        end
    end

    // Analog controls
    always_ff @(posedge I_CLOCK) begin
        if (!I_NRST) begin
            O_DAC_CODE <= 11'h000;
            O_MUX_SEL <= 3'h0;
            O_PIN_ATTENUATION <= `AAM_ATT_3V2;
            O_CONVERTING <= 1'b0;
        end else begin
            O_DAC_CODE <= code;
            O_PIN_ATTENUATION <= cfg[3:0]; // [RULE12]
            O_CONVERTING <= (state == AAM_DEV_CONVERT) & ch_on;
            if (ch == `AAM_CH_PIN) begin
                O_MUX_SEL <= {1'b0, en[1:0]}; // [RULE9]
            end else if (ch == `AAM_CH_SUPPLY) begin
                O_MUX_SEL <= `AAM_MUX_SUPPLY;
            end else begin
                O_MUX_SEL <= `AAM_MUX_TEMP;
            end
        end
    end

endmodule

// ---- hw/aam_consts.svh ----
`ifndef AAM_CONSTS_SVH
`define AAM_CONSTS_SVH

// Command and reply framing
`define AAM_OPCODE 8'h14
`define AAM_CTS_BYTE 8'hFF
`define AAM_REPLY_LAST 4'h8
`define AAM_CMD_LAST 2'h2

// Channel enable byte fields
`define AAM_EN_TEMP_BIT 4
`define AAM_EN_SUPPLY_BIT 3
`define AAM_EN_PIN_BIT 2
`define AAM_EN_USED_MASK 8'h1F

// Configuration byte
`define AAM_CFG_DEFAULT 8'hCC
`define AAM_ATT_0V8 4'h0
`define AAM_ATT_1V6 4'h4
`define AAM_ATT_2V4 4'h8
`define AAM_ATT_3V6 4'h9
`define AAM_ATT_3V2 4'hC

// Converter
`define AAM_SAR_BITS 11
`define AAM_FULL_RES_SETTING 4'hA
`define AAM_SAR_MSB_MASK 11'h400
`define AAM_SLOT_LAST 4'hF
`define AAM_SLOT_SHIFT 4
`define AAM_SLOT_MIN 24'h00_0005
`define AAM_CONV_DIVIDER 12

// Analog multiplexer codes
`define AAM_MUX_SUPPLY 3'h4
`define AAM_MUX_TEMP 3'h5

// Channel order in the reply
`define AAM_CH_PIN 2'h0
`define AAM_CH_SUPPLY 2'h1
`define AAM_CH_TEMP 2'h2

// Host register map, byte offsets
`define AAM_REG_CTRL 8'h00
`define AAM_REG_STATUS 8'h04
`define AAM_REG_PIN_RAW 8'h08
`define AAM_REG_SUPPLY_RAW 8'h0C
`define AAM_REG_TEMP_RAW 8'h10
`define AAM_REG_TEMP_SCALED 8'h14
`define AAM_REG_SUPPLY_SCALED 8'h18
`define AAM_REG_PIN_DIV 8'h1C
`define AAM_CTRL_START_BIT 16
`define AAM_STATUS_DONE_BIT 1

// Host conversion constants
`define AAM_TEMP_MULT 32'h0000_0238
`define AAM_TEMP_OFFSET 32'h000B_9A00
`define AAM_SUPPLY_MULT 32'h0000_0003
`define AAM_DIV_0V8 32'h0003_E800
`define AAM_DIV_1V6 32'h0001_F400
`define AAM_DIV_2V4 32'h0001_4D55
`define AAM_DIV_3V6 32'h0000_A6AA
`define AAM_DIV_3V2 32'h0000_FA00

`endif

// ---- hw/aam_pkg.sv ----
package aam_pkg;
    typedef enum logic [4:0] {
        AAM_DEV_IDLE    = 5'b0_0001,
        AAM_DEV_GET_EN  = 5'b0_0010,
        AAM_DEV_GET_CFG = 5'b0_0100,
        AAM_DEV_CONVERT = 5'b0_1000,
        AAM_DEV_REPLY   = 5'b1_0000
    } aam_dev_state_t;

    typedef enum logic [2:0] {
        AAM_HOST_IDLE = 3'b001,
        AAM_HOST_SEND = 3'b010,
        AAM_HOST_RECV = 3'b100
    } aam_host_state_t;
endpackage

// ---- hw/aam_link.sv ----
`timescale 1ns/1ps
interface aam_link;
    logic cmd_valid;
    logic [7:0] cmd_data;
    logic cmd_ready;
    logic rsp_valid;
    logic [7:0] rsp_data;
    logic rsp_ready;

    modport device (
        input cmd_valid, cmd_data, rsp_ready,
        output cmd_ready, rsp_valid, rsp_data
    );
    modport host (
        output cmd_valid, cmd_data, rsp_ready,
        input cmd_ready, rsp_valid, rsp_data
    );
endinterface

// ---- hw/aam_host.sv ----
`timescale 1ns/1ps
`include "aam_consts.svh"

module aam_host import aam_pkg::*; (
    // Clock and reset
    input wire logic I_CLOCK,
    input wire logic I_NRST,
    // AHB-Lite slave
    input wire logic I_HSEL,
    input wire logic [31:0] I_HADDR,
    input wire logic [1:0] I_HTRANS,
    input wire logic I_HWRITE,
    input wire logic [2:0] I_HSIZE,
    input wire logic [31:0] I_HWDATA,
    input wire logic I_HREADY,
    output logic [31:0] O_HRDATA,
    output logic O_HREADYOUT,
    output logic O_HRESP,
    // Link to device
    aam_link.host LINK
);

    aam_host_state_t state;
    logic [7:0] ctrl_en;
    logic [7:0] ctrl_cfg;
    logic done;
    logic [1:0] cmd_idx;
    logic [3:0] rsp_idx;
    logic [7:0] cmd_byte;
    logic [7:0] rx [0:5];
    logic wr_pend;
    logic [7:0] wr_addr;
    logic addr_phase;
    logic start;
    logic [15:0] pin_raw;
    logic [15:0] supply_raw;
    logic [15:0] temp_raw;
    logic [3:0] att;
    logic [31:0] pin_div;
    logic [31:0] read_mux;

    assign O_HREADYOUT = 1'b1;
    assign O_HRESP = 1'b0;
    assign addr_phase = I_HSEL & I_HREADY & I_HTRANS[1];
    assign start = wr_pend && wr_addr == `AAM_REG_CTRL && I_HWDATA[`AAM_CTRL_START_BIT] && state == AAM_HOST_IDLE;
    assign pin_raw = {rx[0], rx[1]};
    assign supply_raw = {rx[2], rx[3]};
    assign temp_raw = {rx[4], rx[5]};
    assign att = (ctrl_cfg == 8'h00) ? `AAM_ATT_3V2 : ctrl_cfg[3:0];

    // Divisor times 100 for the chosen range
    always_comb begin
        case (att)
            `AAM_ATT_0V8: pin_div = `AAM_DIV_0V8; // [RULE8]
            `AAM_ATT_1V6: pin_div = `AAM_DIV_1V6;
            `AAM_ATT_2V4: pin_div = `AAM_DIV_2V4;
            `AAM_ATT_3V6: pin_div = `AAM_DIV_3V6;
            `AAM_ATT_3V2: pin_div = `AAM_DIV_3V2;
            default: pin_div = 32'h0000_0000;
        endcase
    end

    always_comb begin
        if (I_HADDR[7:0] == `AAM_REG_CTRL) begin
            read_mux = {16'h0000, ctrl_cfg, ctrl_en};
        end else if (I_HADDR[7:0] == `AAM_REG_STATUS) begin
            read_mux = {30'h0000_0000, done, state != AAM_HOST_IDLE};
        end else if (I_HADDR[7:0] == `AAM_REG_PIN_RAW) begin
            read_mux = {16'h0000, pin_raw};
        end else if (I_HADDR[7:0] == `AAM_REG_SUPPLY_RAW) begin
            read_mux = {16'h0000, supply_raw};
        end else if (I_HADDR[7:0] == `AAM_REG_TEMP_RAW) begin
            read_mux = {16'h0000, temp_raw};
        end else if (I_HADDR[7:0] == `AAM_REG_TEMP_SCALED) begin
            read_mux = {16'h0000, temp_raw} * `AAM_TEMP_MULT - `AAM_TEMP_OFFSET; // [RULE6]
        end else if (I_HADDR[7:0] == `AAM_REG_SUPPLY_SCALED) begin
            read_mux = {16'h0000, supply_raw} * `AAM_SUPPLY_MULT; // [RULE7]
        end else if (I_HADDR[7:0] == `AAM_REG_PIN_DIV) begin
            read_mux = pin_div;
        end else begin
            read_mux = 32'h0000_0000;
        end
    end

    // Bus slave, zero wait
    always_ff @(posedge I_CLOCK) begin
        if (!I_NRST) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
            O_HRDATA <= 32'h0000_0000;
        end else begin
            wr_pend <= addr_phase & I_HWRITE;
            wr_addr <= I_HADDR[7:0];
            if (addr_phase && !I_HWRITE) begin
                O_HRDATA <= read_mux;
            end
        end
    end

    // Control and status
    always_ff @(posedge I_CLOCK) begin
        if (!I_NRST) begin
            ctrl_en <= 8'h00;
            ctrl_cfg <= 8'h00;
            done <= 1'b0;
        end else begin
            if (wr_pend && wr_addr == `AAM_REG_CTRL && state == AAM_HOST_IDLE) begin
                ctrl_en <= I_HWDATA[7:0] & `AAM_EN_USED_MASK; // [RULE3]
                ctrl_cfg <= I_HWDATA[15:8];
            end
            // A finishing reply beats a clear in the same cycle
            if (LINK.rsp_valid && LINK.rsp_ready && rsp_idx == `AAM_REPLY_LAST) begin
                done <= 1'b1;
            end else if (wr_pend && wr_addr == `AAM_REG_STATUS && I_HWDATA[`AAM_STATUS_DONE_BIT]) begin
                done <= 1'b0;
            end
        end
    end

    assign LINK.cmd_valid = (state == AAM_HOST_SEND);
    assign LINK.cmd_data = cmd_byte;
    assign LINK.rsp_ready = (state == AAM_HOST_RECV);

    // Link master
    always_ff @(posedge I_CLOCK) begin
        if (!I_NRST) begin
            state <= AAM_HOST_IDLE;
            cmd_idx <= 2'h0;
            rsp_idx <= 4'h0;
            cmd_byte <= 8'h00;
        end else begin
            case (state)
                AAM_HOST_IDLE: begin
                    if (start) begin
                        state <= AAM_HOST_SEND;
                        cmd_idx <= 2'h0;
                        cmd_byte <= `AAM_OPCODE; // [RULE2]
                    end
                end
                AAM_HOST_SEND: begin
                    if (LINK.cmd_ready) begin
                        cmd_idx <= cmd_idx + 2'd1;
                        if (cmd_idx == 2'h0) begin
                            cmd_byte <= ctrl_en; // [RULE2]
                        end else begin
                            cmd_byte <= ctrl_cfg;
                        end
                        if (cmd_idx == `AAM_CMD_LAST) begin
                            state <= AAM_HOST_RECV;
                            rsp_idx <= 4'h0;
                        end
                    end
                end
                AAM_HOST_RECV: begin
                    if (LINK.rsp_valid) begin
                        rsp_idx <= rsp_idx + 4'd1;
                        if (rsp_idx == `AAM_REPLY_LAST) begin
                            state <= AAM_HOST_IDLE;
                        end
                    end
                end
                default: state <= AAM_HOST_IDLE;
            endcase
        end
    end

    // Result bytes 1..6 of the reply
    always_ff @(posedge I_CLOCK) begin
        if (!I_NRST) begin
            for (int i = 0; i < 6; i++) begin
                rx[i] <= 8'h00;
            end
        end else if (state == AAM_HOST_RECV && LINK.rsp_valid && rsp_idx >= 4'h1 && rsp_idx <= 4'h6) begin
            rx[3'(rsp_idx - 4'd1)] <= LINK.rsp_data; // [RULE4]
        end
    end

endmodule

// ---- verification/aam_link_sva.sv ----
`timescale 1ns/1ps
module aam_link_sva #(
    parameter int unsigned CONV_DIVIDER = 12
) (
    // Clock and reset
    input wire logic I_CLOCK,
    input wire logic I_NRST,
    // Link signals
    input wire logic cmd_valid,
    input wire logic [7:0] cmd_data,
    input wire logic cmd_ready,
    input wire logic rsp_valid,
    input wire logic [7:0] rsp_data,
    input wire logic rsp_ready
);
    logic cgo, rgo;
    logic [1:0] ccnt;
    logic [3:0] rcnt;
    logic [7:0] en;
    logic [31:0] lat, wt;
    logic zero_slot;
    assign cgo = cmd_valid && cmd_ready;
    assign rgo = rsp_valid && rsp_ready;
    assign zero_slot = (rcnt > 4'h6) || (rcnt inside {4'h1, 4'h2} && !en[2])
        || (rcnt inside {4'h3, 4'h4} && !en[3]) || (rcnt inside {4'h5, 4'h6} && !en[4]);
    // Cycles one channel takes, slot floor of five
    function automatic logic [31:0] chan(input logic on, input logic [7:0] cfg);
        logic [31:0] s;
        s = (CONV_DIVIDER << ((cfg == 8'h00) ? 5'hD : cfg[7:4] + 5'h1)) >> 4;
        return on ? ((s < 5) ? 32'h50 : s << 4) : 32'h1;
    endfunction
    always_ff @(posedge I_CLOCK) begin
        if (!I_NRST) ccnt <= 2'h0;
        else if (cgo) ccnt <= (ccnt == 2'h2) ? 2'h0 : ccnt + 2'h1;
    end
    always_ff @(posedge I_CLOCK) begin
        if (cgo && ccnt == 2'h1) en <= cmd_data;
    end
    // Tolerance of two cycles, edge counting is loose at both ends
    always_ff @(posedge I_CLOCK) begin
        if (cgo && ccnt == 2'h2) begin
            lat <= chan(en[2], cmd_data) + chan(en[3], cmd_data) + chan(en[4], cmd_data) + 32'h1;
            wt <= 32'h0;
        end else if (!rsp_valid) wt <= wt + 32'h1;
    end
    always_ff @(posedge I_CLOCK) begin
        if (!I_NRST || cgo) rcnt <= 4'h0;
        else if (rgo) rcnt <= rcnt + 4'h1;
    end
    default clocking cb @(posedge I_CLOCK);
    endclocking
    default disable iff (!I_NRST);
    chk_cmd_hold: assert property (cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_data))
        else $error("command byte changed before taken");
    chk_rsp_hold: assert property (rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_data))
        else $error("reply byte changed before taken");
    chk_opcode_first: assert property (cgo && ccnt == 2'h0 |-> cmd_data == 8'h14)
        else $error("first command byte not the opcode");
    chk_enable_top: assert property (cgo && ccnt == 2'h1 |-> cmd_data[7:5] == 3'h0)
        else $error("enable byte top bits set");
    chk_convert_gap: assert property (cgo && ccnt == 2'h2 |=> (!cmd_ready && !rsp_valid) [*3])
        else $error("link active during conversion");
    chk_cts_first: assert property (rsp_valid && rcnt == 4'h0 |-> rsp_data == 8'hFF)
        else $error("reply does not open with ready byte");
    chk_reply_len: assert property (rgo && rcnt == 4'h8 |=> !rsp_valid)
        else $error("reply longer than nine bytes");
    chk_conv_time: assert property ($rose(rsp_valid) |-> wt + 32'h2 >= lat && wt <= lat + 32'h2)
        else $error("conversion time off");
    chk_zero_fields: assert property (rsp_valid && zero_slot |-> rsp_data == 8'h00)
        else $error("skipped or reserved field not zero");
endmodule

// ---- verification/tb.sv ----
`timescale 1ns/1ps
module tb;
    localparam int unsigned DIV = 1;
    logic I_CLOCK = 1'b0;
    logic I_NRST = 1'b0;
    logic hsel = 1'b0, hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic hrdy, hresp, conv, cmp;
    logic [10:0] ana [6];
    logic [10:0] dac;
    logic [2:0] mux;
    logic [3:0] att;
    logic [7:0] cq [$], rq [$];
    logic [3:0] atts [6] = '{4'h0, 4'h4, 4'h8, 4'h9, 4'hC, 4'h3};
    int mismatches = 0, compares = 0, cycles = 0, conv_cycles = 0;
    aam_link link ();
    // Ideal comparator on the selected input
    assign cmp = (ana[mux] >= dac);
    aam_host aam_host_inst (.I_CLOCK(I_CLOCK), .I_NRST(I_NRST), .I_HSEL(hsel), .I_HADDR(haddr),
        .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata), .I_HREADY(hrdy),
        .O_HRDATA(hrdata), .O_HREADYOUT(hrdy), .O_HRESP(hresp), .LINK(link));
    aam_device #(.CONV_DIVIDER(DIV)) aam_device_inst (.I_CLOCK(I_CLOCK), .I_NRST(I_NRST), .LINK(link),
        .I_COMPARE(cmp), .O_DAC_CODE(dac), .O_MUX_SEL(mux), .O_PIN_ATTENUATION(att), .O_CONVERTING(conv));
    aam_link_sva #(.CONV_DIVIDER(DIV)) aam_link_sva_inst (.I_CLOCK(I_CLOCK), .I_NRST(I_NRST),
        .cmd_valid(link.cmd_valid), .cmd_data(link.cmd_data), .cmd_ready(link.cmd_ready),
        .rsp_valid(link.rsp_valid), .rsp_data(link.rsp_data), .rsp_ready(link.rsp_ready));
    initial begin
        forever #50 I_CLOCK = ~I_CLOCK;
    end
    always @(posedge I_CLOCK) begin
        if (link.cmd_valid && link.cmd_ready) cq.push_back(link.cmd_data);
        if (link.rsp_valid && link.rsp_ready) rq.push_back(link.rsp_data);
        if (conv) conv_cycles++;
    end
    task automatic complete_run;
        if (mismatches == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // A hung handshake ends the run here
    always @(posedge I_CLOCK) begin
        cycles++;
        if (cycles == 50000) begin
            mismatches++;
            complete_run();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge I_CLOCK);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        @(posedge I_CLOCK);
        while (hrdy !== 1'b1) @(posedge I_CLOCK);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge I_CLOCK);
        while (hrdy !== 1'b1) @(posedge I_CLOCK);
        r = hrdata;
    endtask
    // Top bits resolved MSB first, the rest left zero
    function automatic logic [31:0] sar(input logic [10:0] v, input logic [3:0] ud);
        logic [10:0] m;
        m = (ud >= 4'hA) ? 11'h7FF : ~(11'h7FF >> (ud + 4'h1));
        return {21'h0, v & m};
    endfunction
    function automatic logic [31:0] divx(input logic [3:0] a);
        case (a)
            4'h0: return 32'h0003_E800;
            4'h4: return 32'h0001_F400;
            4'h8: return 32'h0001_4D55;
            4'h9: return 32'h0000_A6AA;
            4'hC: return 32'h0000_FA00;
            default: return 32'h0;
        endcase
    endfunction
    // Sixteen slots per enabled channel, slot floor of five cycles
    function automatic int busy_len(input logic [7:0] en, input logic [3:0] ud);
        int s;
        s = (DIV << (ud + 1)) >> 4;
        if (s < 5) s = 5;
        return 16 * s * (int'(en[2]) + int'(en[3]) + int'(en[4]));
    endfunction
    task automatic run(input logic [7:0] en, input logic [7:0] cfg);
        logic [10:0] v [6];
        logic [31:0] e [3];
        logic [31:0] x [6];
        logic [7:0] b [9];
        logic [7:0] c;
        logic [31:0] r;
        int i;
        int cv;
        c = (cfg == 8'h00) ? 8'hCC : cfg;
        for (i = 0; i < 6; i++) begin
            v[i] = 11'($urandom);
            ana[i] <= v[i];
        end
        e[0] = en[2] ? sar(v[en[1:0]], c[7:4]) : 32'h0;
        e[1] = en[3] ? sar(v[4], c[7:4]) : 32'h0;
        e[2] = en[4] ? sar(v[5], c[7:4]) : 32'h0;
        b = '{8'hFF, e[0][15:8], e[0][7:0], e[1][15:8], e[1][7:0], e[2][15:8], e[2][7:0], 8'h00, 8'h00};
        x = '{e[0], e[1], e[2], e[2] * 32'h0000_0238 - 32'h000B_9A00, e[1] * 32'h3, divx(c[3:0])};
        cq.delete();
        rq.delete();
        cv = conv_cycles;
        ahb(1'b1, 8'h00, {15'h0, 1'b1, cfg, en}, r);
        // Second start while busy must not disturb the run
        ahb(1'b1, 8'h00, 32'h0001_001C, r);
        ahb(1'b1, 8'h20, 32'hFFFF_FFFF, r);
        ahb(1'b0, 8'h20, 32'h0, r);
        chk(r, 32'h0);
        ahb(1'b0, 8'h00, 32'h0, r);
        chk(r & 32'h0000_FFFF, {16'h0, cfg, 3'h0, en[4:0]});
        do ahb(1'b0, 8'h04, 32'h0, r); while (r[1] !== 1'b1);
        chk(32'(cq.size()), 32'h3);
        chk({24'h0, cq[0]}, 32'h14);
        chk({24'h0, cq[1]}, {27'h0, en[4:0]});
        chk({24'h0, cq[2]}, {24'h0, cfg});
        chk(32'(rq.size()), 32'h9);
        chk(32'(conv_cycles - cv), 32'(busy_len(en, c[7:4])));
        for (i = 0; i < 9; i++) chk({24'h0, rq[i]}, {24'h0, b[i]});
        for (i = 0; i < 6; i++) begin
            ahb(1'b0, 8'(8 + 4 * i), 32'h0, r);
            chk(r, x[i]);
        end
        chk({31'h0, hresp}, 32'h0);
        chk({28'h0, att}, {28'h0, c[3:0]});
        ahb(1'b1, 8'h04, 32'h2, r);
        ahb(1'b0, 8'h04, 32'h0, r);
        chk(r, 32'h0);
    endtask
    initial begin
        logic [31:0] r;
        foreach (ana[i]) ana[i] = 11'h0;
        void'($urandom(32'h2279_f70a));
        repeat (12) @(posedge I_CLOCK);
        I_NRST <= 1'b1;
        @(posedge I_CLOCK);
        chk({28'h0, att}, 32'hC);
        chk({17'h0, conv, mux, dac}, 32'h0);
        ahb(1'b0, 8'h04, 32'h0, r);
        chk(r, 32'h0);
        run(8'hFC, 8'hA0);
        run(8'h05, 8'h00);
        run(8'h06, 8'h14);
        run(8'h0F, 8'h38);
        run(8'h10, 8'h59);
        run(8'h00, 8'h03);
        repeat (8) run(8'($urandom), {4'($urandom_range(7, 0)), atts[$urandom_range(5, 0)]});
        complete_run();
    end
endmodule
